// [pkg/key_scan_pkg.sv]
// Contract
// - Twelve low segment outputs double as scan columns
// - Columns driven only in short slot, display undisturbed
// - Four shared sense pins, enabled by fabrication option
// - Halt release by key press or scan cycle
// - Single column selected by low field indices 0-11
// - Bit5 drives no columns, else bit4 drives all
// - Group mode drives eights, fours or pairs
// - Active column high for LED, low for LCD
// - Sense rising edge sets key wake request flag
// - Request set from clear with wake enabled and bit6 low sets start flag, leaves halt
// - Sense states latched at end of scan cycle
// - Flag clear with operand 20h clears request
// - Scan rate is frame rate times duty times two
`default_nettype none
package key_scan_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_PATTERN  = 8'h00;
    localparam logic [7:0] OFS_CONTROL  = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_CLEAR    = 8'h0C;
    localparam logic [7:0] OFS_SENSE    = 8'h10;

    // Field positions
    localparam int CTL_WAKE_EN  = 0;
    localparam int CTL_LED_MODE = 1;
    localparam int CTL_HALT     = 2;
    localparam int ST_REQUEST   = 0;
    localparam int ST_START     = 1;
    localparam int ST_HALT      = 2;

    // Reset values and operands
    localparam logic [7:0] PATTERN_RST    = 8'h20;
    localparam logic [7:0] CLEAR_KEY_WAKE = 8'h20;

    // Display timing and scan slot
    localparam int CLK_HZ        = 200_000_000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int FRAME_HZ      = 32;
    localparam int DUTY_PHASES   = 5;
    localparam int SCAN_FACTOR   = 2;
    localparam int SCAN_CYCLES   = CLK_HZ / (FRAME_HZ * DUTY_PHASES * SCAN_FACTOR);
    localparam int SLOT_NS       = 80;
    localparam int SLOT_CYCLES   = (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [0:0] {
        PH_DISPLAY = 1'b0,
        PH_SCAN    = 1'b1
    } phase_t;

    typedef struct packed {
        logic       group_mode_bit;
        logic       halt_source_select;
        logic       off_or_pairs;
        logic       all_or_quads;
        logic [3:0] column_sel;
    } scan_cfg_t;

    typedef struct packed {
        logic [11:0] level;
        logic [11:0] oe_n;
    } pin_drive_t;

endpackage : key_scan_pkg
`default_nettype wire

// [core/key_matrix_scanner.sv]
`default_nettype none
module key_matrix_scanner #(
    parameter int SCAN_CYCLES = key_scan_pkg::SCAN_CYCLES,
    parameter int SLOT_CYCLES = key_scan_pkg::SLOT_CYCLES,
    parameter bit SENSE_FITTED = 1'b1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [11:0] display_level,
    input  wire logic [11:0] display_oe_n,
    input  wire logic [3:0]  key_sense_inputs,
    output logic      [11:0] scan_columns,
    output logic      [11:0] scan_columns_oe_n,
    output logic             halt_mode,
    output logic             key_start_condition_flag
);

    localparam int CNT_W = $clog2(SCAN_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SCAN_CYCLES - 1);
    localparam logic [CNT_W-1:0] SLOT_START = CNT_W'(SCAN_CYCLES - SLOT_CYCLES);

    // Column drive mask from the pattern word
    function automatic logic [11:0] column_mask(input key_scan_pkg::scan_cfg_t c);
        logic [11:0] m;
        logic [2:0]  pair;
        m    = 12'h000;
        pair = c.column_sel[3:1];
        if (!c.group_mode_bit) begin
            if (c.off_or_pairs) begin
                m = 12'h000;
            end else if (c.all_or_quads) begin
                m = 12'hFFF;
            end else if (c.column_sel < 4'hC) begin
                m = 12'(12'h001 << c.column_sel);
            end
        end else if (!c.off_or_pairs) begin
            m = c.column_sel[3] ? 12'hF00 : 12'h0FF;
        end else if (!c.all_or_quads) begin
            case (c.column_sel[3:2])
                2'h0:    m = 12'h00F;
                2'h1:    m = 12'h0F0;
                2'h2:    m = 12'hF00;
                default: m = 12'h000;
            endcase
        end else if (pair < 3'h6) begin
            m = 12'(12'h003 << {pair, 1'b0});
        end
        return m;
    endfunction : column_mask

    // APB and software-visible state
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pready_r;
    logic        pready_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;
    key_scan_pkg::scan_cfg_t pattern_r;
    key_scan_pkg::scan_cfg_t pattern_nxt;
    logic        wake_en_r;
    logic        wake_en_nxt;
    logic        led_mode_r;
    logic        led_mode_nxt;

    // Scan timing state
    logic [CNT_W-1:0]     cnt_r;
    logic [CNT_W-1:0]     cnt_nxt;
    key_scan_pkg::phase_t phase_r;
    key_scan_pkg::phase_t phase_nxt;

    // Sense and flag state
    logic [3:0] sense_meta_r;
    logic [3:0] sense_s2_r;
    logic [3:0] sense_s3_r;
    logic [3:0] sense_q_r;
    logic [3:0] sense_q_nxt;
    logic [3:0] latch_r;
    logic [3:0] latch_nxt;
    logic       request_r;
    logic       request_nxt;
    logic       start_r;
    logic       start_nxt;
    logic       halt_r;
    logic       halt_nxt;

    // Pin state
    key_scan_pkg::pin_drive_t pins_r;
    key_scan_pkg::pin_drive_t pins_nxt;

    logic        acc_wr;
    logic        scan_end;
    logic        key_rise;
    logic [3:0]  sense_new;

    assign acc_wr = psel && penable && pready_r && pwrite;
    assign scan_end = (cnt_r == CNT_LAST);

    // APB decode; every access completes in one access cycle
    always_comb begin
        prdata_nxt   = 32'h0000_0000;
        pready_nxt   = psel && !penable;
        pslverr_nxt  = 1'b0;
        pattern_nxt  = pattern_r;
        wake_en_nxt  = wake_en_r;
        led_mode_nxt = led_mode_r;
        if (psel && !penable) begin
            case (paddr)
                key_scan_pkg::OFS_PATTERN: begin
                    prdata_nxt[7:0] = pattern_r;
                end
                key_scan_pkg::OFS_CONTROL: begin
                    prdata_nxt[key_scan_pkg::CTL_WAKE_EN]  = wake_en_r;
                    prdata_nxt[key_scan_pkg::CTL_LED_MODE] = led_mode_r;
                    prdata_nxt[key_scan_pkg::CTL_HALT]     = halt_r;
                end
                key_scan_pkg::OFS_STATUS: begin
                    prdata_nxt[key_scan_pkg::ST_REQUEST] = request_r;
                    prdata_nxt[key_scan_pkg::ST_START]   = start_r;
                    prdata_nxt[key_scan_pkg::ST_HALT]    = halt_r;
                end
                key_scan_pkg::OFS_CLEAR: begin
                    prdata_nxt = 32'h0000_0000;
                end
                key_scan_pkg::OFS_SENSE: begin
                    prdata_nxt[3:0] = latch_r;
                end
                default: begin
                    pslverr_nxt = 1'b1;
                end
            endcase
        end
        if (acc_wr) begin
            case (paddr)
                key_scan_pkg::OFS_PATTERN: begin
                    pattern_nxt = pwdata[7:0];
                end
                key_scan_pkg::OFS_CONTROL: begin
                    wake_en_nxt  = pwdata[key_scan_pkg::CTL_WAKE_EN];
                    led_mode_nxt = pwdata[key_scan_pkg::CTL_LED_MODE];
                end
                default: begin
                    pattern_nxt = pattern_r;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r   <= 32'h0000_0000;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
            pattern_r  <= key_scan_pkg::PATTERN_RST;
            wake_en_r  <= 1'b0;
            led_mode_r <= 1'b0;
        end else begin
            prdata_r   <= prdata_nxt;
            pready_r   <= pready_nxt;
            pslverr_r  <= pslverr_nxt;
            pattern_r  <= pattern_nxt;
            wake_en_r  <= wake_en_nxt;
            led_mode_r <= led_mode_nxt;
        end
    end

    // Scan cycle counter; the slot sits at the end of each period
    always_comb begin
        cnt_nxt   = scan_end ? '0 : cnt_r + CNT_W'(1);
        phase_nxt = phase_r;
        case (phase_r)
            key_scan_pkg::PH_DISPLAY: begin
                if (cnt_nxt == SLOT_START) begin
                    phase_nxt = key_scan_pkg::PH_SCAN;
                end
            end
            key_scan_pkg::PH_SCAN: begin
                if (scan_end) begin
                    phase_nxt = key_scan_pkg::PH_DISPLAY;
                end
            end
            default: begin
                phase_nxt = key_scan_pkg::PH_DISPLAY;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r   <= '0;
            phase_r <= key_scan_pkg::PH_DISPLAY;
        end else begin
            cnt_r   <= cnt_nxt;
            phase_r <= phase_nxt;
        end
    end

    // Three-stage synchroniser; a change counts once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_meta_r <= 4'h0;
            sense_s2_r   <= 4'h0;
            sense_s3_r   <= 4'h0;
        end else begin
            sense_meta_r <= key_sense_inputs;
            sense_s2_r   <= sense_meta_r;
            sense_s3_r   <= sense_s2_r;
        end
    end

    // Rows are only trusted while columns are on the pins
    always_comb begin
        sense_new = sense_q_r;
        for (int i = 0; i < 4; i++) begin
            if (sense_s2_r[i] == sense_s3_r[i]) begin
                sense_new[i] = sense_s3_r[i];
            end
        end
        if (!SENSE_FITTED) begin
            sense_new = 4'h0;
        end
        key_rise = 1'b0;
        if (phase_r == key_scan_pkg::PH_SCAN) begin
            key_rise = |(sense_new & ~sense_q_r);
        end
    end

    // Flags; for request and start a set in the same cycle as a clear wins, for halt the release wins over entry
    always_comb begin
        sense_q_nxt = sense_new;
        latch_nxt   = latch_r;
        request_nxt = request_r;
        start_nxt   = start_r;
        halt_nxt    = halt_r;
        if (phase_r != key_scan_pkg::PH_SCAN) begin
            sense_q_nxt = 4'h0;
        end
        if (phase_r == key_scan_pkg::PH_SCAN && scan_end) begin
            latch_nxt = sense_new;
        end
        if (acc_wr && paddr == key_scan_pkg::OFS_CLEAR
            && (pwdata[7:0] & key_scan_pkg::CLEAR_KEY_WAKE) != 8'h00) begin
            request_nxt = 1'b0;
        end
        if (acc_wr && paddr == key_scan_pkg::OFS_STATUS
            && pwdata[key_scan_pkg::ST_START]) begin
            start_nxt = 1'b0;
        end
        if (acc_wr && paddr == key_scan_pkg::OFS_CONTROL
            && pwdata[key_scan_pkg::CTL_HALT]) begin
            halt_nxt = 1'b1;
        end
        if (key_rise) begin
            request_nxt = 1'b1;
        end
        if (key_rise && !request_r && wake_en_r
            && !pattern_r.halt_source_select) begin
            start_nxt = 1'b1;
            halt_nxt  = 1'b0;
        end
        if (pattern_r.halt_source_select && scan_end) begin
            halt_nxt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_q_r <= 4'h0;
            latch_r   <= 4'h0;
            request_r <= 1'b0;
            start_r   <= 1'b0;
            halt_r    <= 1'b0;
        end else begin
            sense_q_r <= sense_q_nxt;
            latch_r   <= latch_nxt;
            request_r <= request_nxt;
            start_r   <= start_nxt;
            halt_r    <= halt_nxt;
        end
    end

    // Segment pins: display data outside the slot, column pattern inside
    always_comb begin
        logic [11:0] mask;
        mask = column_mask(pattern_nxt);
        pins_nxt.level = display_level;
        pins_nxt.oe_n  = display_oe_n;
        if (phase_nxt == key_scan_pkg::PH_SCAN) begin
            pins_nxt.oe_n = ~mask;
            pins_nxt.level = led_mode_r ? mask : ~mask;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_r.level <= 12'h000;
            pins_r.oe_n  <= 12'hFFF;
        end else begin
            pins_r <= pins_nxt;
        end
    end

    // All outputs straight from flip-flops
    assign prdata                   = prdata_r;
    assign pready                   = pready_r;
    assign pslverr                  = pslverr_r;
    assign scan_columns             = pins_r.level;
    assign scan_columns_oe_n        = pins_r.oe_n;
    assign halt_mode                = halt_r;
    assign key_start_condition_flag = start_r;

endmodule : key_matrix_scanner
`default_nettype wire

// [testbench/key_scan_exp.svh]
`ifndef KEY_SCAN_EXP_SVH
`define KEY_SCAN_EXP_SVH
// Columns a pattern word drives in the scan slot, bit 0 is the first column
function automatic logic [11:0] col_mask(input logic [7:0] x);
    if (!x[7]) begin
        return x[5] ? 12'h000 : x[4] ? 12'hFFF : (x[3:0] < 4'hC) ? 12'h001 << x[3:0] : 12'h000;
    end
    if (!x[5]) begin
        return x[3] ? 12'hF00 : 12'h0FF;
    end
    if (!x[4]) begin
        return (x[3:2] == 2'h3) ? 12'h000 : 12'h00F << {x[3:2], 2'h0};
    end
    return (x[3:1] > 3'h5) ? 12'h000 : 12'h003 << {x[3:1], 1'h0};
endfunction : col_mask
`endif

// [testbench/key_scan_chk.sv]
`default_nettype none
`include "key_scan_exp.svh"
module key_scan_chk #(
    parameter int SCAN_CYCLES = 64,
    parameter int SLOT_CYCLES = 8
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [11:0] display_level,
    input wire logic [11:0] display_oe_n,
    input wire logic [3:0]  key_sense_inputs,
    input wire logic [11:0] scan_columns,
    input wire logic [11:0] scan_columns_oe_n,
    input wire logic        halt_mode,
    input wire logic        key_start_condition_flag
);
    logic [31:0] cnt_r, cnt_nxt;
    logic [7:0]  pat_r, pat_nxt;
    logic [1:0]  ctl_r, ctl_nxt;
    logic        wr, mid;
    assign wr = psel && penable && pready && pwrite;
    // Keep only a middle stretch so counter alignment cannot cause false alarms
    assign mid = (cnt_r > 32'h3) && (cnt_r < 32'(SCAN_CYCLES - SLOT_CYCLES - 4));
    // Shadow of the pattern and mode written over the bus
    always_comb begin
        cnt_nxt = (cnt_r == 32'(SCAN_CYCLES - 1)) ? 32'h0 : cnt_r + 32'h1;
        pat_nxt = (wr && paddr == 8'h00) ? pwdata[7:0] : pat_r;
        ctl_nxt = (wr && paddr == 8'h04) ? pwdata[1:0] : ctl_r;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 32'h0;
            pat_r <= 8'h20;
            ctl_r <= 2'h0;
        end else begin
            cnt_r <= cnt_nxt;
            pat_r <= pat_nxt;
            ctl_r <= ctl_nxt;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_error_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error response");
    a_unmapped_error: assert property (psel && !penable && paddr > 8'h10 |=> pslverr)
        else $error("unmapped access not refused");
    a_display_pass: assert property (mid |-> scan_columns_oe_n == $past(display_oe_n)
        && scan_columns == $past(display_level)) else $error("display disturbed");
    a_column_mask: assert property (scan_columns_oe_n != $past(display_oe_n) && $stable(pat_r)
        |-> scan_columns_oe_n == ~col_mask(pat_r)) else $error("wrong columns driven");
    a_active_level: assert property (scan_columns_oe_n != $past(display_oe_n) && $stable(ctl_r)
        |-> (scan_columns & ~scan_columns_oe_n) == (ctl_r[1] ? ~scan_columns_oe_n : 12'h000))
        else $error("wrong active column level");
    a_start_sticky: assert property (key_start_condition_flag
        && !(wr && paddr == 8'h08 && pwdata[1]) |=> key_start_condition_flag)
        else $error("start flag dropped");
    a_start_leaves_halt: assert property ($rose(key_start_condition_flag) |-> !halt_mode)
        else $error("start without leaving halt");
    a_start_needs_wake: assert property ($rose(key_start_condition_flag) |-> ctl_r[0])
        else $error("start without wake enable");
    a_halt_entry: assert property (wr && paddr == 8'h04 && pwdata[2] |=> halt_mode)
        else $error("halt not entered");
    c_start: cover property ($rose(key_start_condition_flag));
    c_refused: cover property (pslverr);
    c_scan_release: cover property ($fell(halt_mode) && !key_start_condition_flag);
endmodule : key_scan_chk
bind key_matrix_scanner key_scan_chk #(.SCAN_CYCLES(SCAN_CYCLES), .SLOT_CYCLES(SLOT_CYCLES)) chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .display_level(display_level), .display_oe_n(display_oe_n),
    .key_sense_inputs(key_sense_inputs), .scan_columns(scan_columns),
    .scan_columns_oe_n(scan_columns_oe_n), .halt_mode(halt_mode),
    .key_start_condition_flag(key_start_condition_flag));
`default_nettype wire

// [testbench/key_matrix_model.sv]
`default_nettype none
module key_matrix_model (
    input wire logic [11:0] cols,
    input wire logic [11:0] cols_oe_n,
    input wire logic        active_high,
    input wire logic [47:0] pressed,
    output logic     [3:0]  rows
);
    timeunit 1ns;
    timeprecision 1ps;
    // A closed key passes a driven active column to its row; open rows sit at pull-down level
    // Sense port is taken as already set to pulled-down inputs, so rows never float
    always_comb begin
        for (int r = 0; r < 4; r++) begin
            rows[r] = |(pressed[r*12 +: 12] & ~cols_oe_n & (active_high ? cols : ~cols));
        end
    end
endmodule : key_matrix_model
`default_nettype wire

// [testbench/test_key_matrix_scanner.sv]
`default_nettype none
`include "key_scan_exp.svh"
module test_key_matrix_scanner;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SCAN = 64;
    localparam int SLOT = 8;
    logic        pclk, presetn, psel, penable, pwrite, er, led, pready, pslverr;
    logic        halt_mode, key_start_condition_flag;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] display_level, display_oe_n, scan_columns, scan_columns_oe_n;
    logic [3:0]  key_sense_inputs;
    logic [47:0] pressed;
    int          errors, check_count;
    logic [7:0]  pats [27] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
        8'h09, 8'h0A, 8'h0B, 8'h10, 8'h20, 8'h80, 8'h88, 8'hC0, 8'hC4, 8'hC8, 8'hCC, 8'hE0,
        8'hE2, 8'hE4, 8'hE6, 8'hE8, 8'hEA, 8'hEC};
    key_matrix_scanner #(.SCAN_CYCLES(SCAN), .SLOT_CYCLES(SLOT)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .display_level(display_level), .display_oe_n(display_oe_n),
        .key_sense_inputs(key_sense_inputs), .scan_columns(scan_columns),
        .scan_columns_oe_n(scan_columns_oe_n), .halt_mode(halt_mode),
        .key_start_condition_flag(key_start_condition_flag));
    key_matrix_model keys (.cols(scan_columns), .cols_oe_n(scan_columns_oe_n),
        .active_high(led), .pressed(pressed), .rows(key_sense_inputs));
    always #2.5 pclk = ~pclk;
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // A used-up bound is a hang: count it and stop
    task automatic limit(input int n, input int lim);
        if (n >= lim) begin
            chk("wait bound", 32'h0, 32'h1);
            wrap_up();
        end
    endtask : limit
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Look mid-cycle so the answer is read while it stands, not racing the edge
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        limit(n, 16);
        rd = prdata;
        er = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask : rdchk
    // Counts consecutive samples with all columns driven (want=1) or not
    task automatic run(input logic want, output int n);
        n = 0;
        while (((scan_columns_oe_n === 12'h000) === want) && n < 4 * SCAN) begin
            @(posedge pclk);
            n++;
        end
        limit(n, 4 * SCAN);
    endtask : run
    task automatic t_regs();
        rdchk(8'h00, 32'h20, "pattern");
        rdchk(8'h04, 32'h0, "control");
        rdchk(8'h08, 32'h0, "status");
        rdchk(8'h10, 32'h0, "sense");
        rdchk(8'h14, 32'h0, "unmapped data");
        chk("unmapped error", 32'h1, {31'h0, er});
    endtask : t_regs
    task automatic t_columns(input logic l);
        int n;
        logic [11:0] m;
        led = l;
        apb(1'b1, 8'h04, {30'h0, l, 1'b0});
        foreach (pats[i]) begin
            m = col_mask(pats[i]);
            apb(1'b1, 8'h00, {24'h0, pats[i]});
            n = 0;
            while (scan_columns_oe_n !== ~m && n < 3 * SCAN) begin
                @(posedge pclk);
                n++;
            end
            chk("column enables", {20'h0, ~m}, {20'h0, scan_columns_oe_n});
            chk("column level", {20'h0, l ? m : 12'h000}, {20'h0, scan_columns & m});
        end
    endtask : t_columns
    task automatic t_rate();
        int n, d, s;
        apb(1'b1, 8'h00, 32'h10);
        run(1'b0, n);
        run(1'b1, n);
        run(1'b0, d);
        run(1'b1, s);
        chk("display length", 32'(SCAN - SLOT), 32'(d));
        chk("slot length", 32'(SLOT), 32'(s));
    endtask : t_rate
    task automatic t_nowake();
        led = 1'b1; // Matrix must see the same active level as the LED mode written below
        apb(1'b1, 8'h00, 32'h00);
        apb(1'b1, 8'h0C, 32'h20);
        apb(1'b1, 8'h04, 32'h6);
        pressed <= 48'h1 << 29;
        repeat (2 * SCAN) @(posedge pclk);
        rdchk(8'h08, 32'h4, "unselected key");
        apb(1'b1, 8'h00, 32'h05);
        repeat (2 * SCAN) @(posedge pclk);
        rdchk(8'h08, 32'h5, "request without wake");
        chk("halt held", 32'h1, {31'h0, halt_mode});
        pressed <= 48'h0;
    endtask : t_nowake
    task automatic t_source();
        int n;
        apb(1'b1, 8'h00, 32'h50);
        apb(1'b1, 8'h04, 32'h6);
        n = 0;
        while (halt_mode !== 1'b0 && n < 3 * SCAN) begin
            @(posedge pclk);
            n++;
        end
        chk("scan cycle release", 32'h0, {31'h0, halt_mode});
    endtask : t_source
    task automatic t_wake();
        int n;
        apb(1'b1, 8'h00, 32'h10);
        apb(1'b1, 8'h0C, 32'h20);
        apb(1'b1, 8'h04, 32'h7);
        @(posedge pclk);
        chk("halt entered", 32'h1, {31'h0, halt_mode});
        pressed <= 48'h1 << 29;
        n = 0;
        while (key_start_condition_flag !== 1'b1 && n < 3 * SCAN) begin
            @(posedge pclk);
            n++;
        end
        limit(n, 3 * SCAN);
        chk("halt left", 32'h0, {31'h0, halt_mode});
        repeat (2 * SCAN) @(posedge pclk);
        rdchk(8'h10, 32'h4, "sense latch");
        pressed <= 48'h0;
        repeat (2 * SCAN) @(posedge pclk);
        rdchk(8'h10, 32'h0, "sense released");
        rdchk(8'h08, 32'h3, "request sticky");
        apb(1'b1, 8'h0C, 32'h20);
        apb(1'b1, 8'h08, 32'h2);
        rdchk(8'h08, 32'h0, "flags cleared");
    endtask : t_wake
    // Hang guard
    initial begin
        repeat (100000) @(posedge pclk);
        chk("run length", 32'h0, 32'h1);
        wrap_up();
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, er, rd} = '0;
        {paddr, pwdata, pressed, errors, check_count} = '0;
        display_level = 12'h555;
        display_oe_n = 12'h555;
        led = 1'b1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        $display("test regs done");
        t_columns(1'b1);
        t_columns(1'b0);
        $display("test columns done");
        t_rate();
        $display("test rate done");
        t_nowake();
        $display("test no wake done");
        t_source();
        $display("test scan release done");
        t_wake();
        $display("test wake done");
        wrap_up();
    end
endmodule : test_key_matrix_scanner
`default_nettype wire
